/* design/alu_and_branch_execute.sv */
// execute stage: arithmetic, logic, compare, skip and branch group
// assumes decode supplies operands in instr_t on the core clock and
// an ahb-lite master reaches the flag, pc, control and cycle registers
`timescale 1ns/1ps

module alu_and_branch_execute
(
    // clock and reset
    input  wire logic             hclk,
    input  wire logic             hresetn,
    // ahb-lite slave
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic                  hreadyout,
    output logic                  hresp,
    output logic [31:0]           hrdata,
    // instruction from decode
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire exec_pkg::instr_t instr,
    // results to register file and program counter
    output logic                  out_valid,
    output exec_pkg::result_t     out,
    output logic [7:0]            flags
);
    import exec_pkg::*;

    typedef enum logic {st_idle, st_busy} state_t;

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [10:0] arith(input logic [7:0] a,
                                          input logic [7:0] b,
                                          input logic ci,
                                          input logic sub);
        logic [8:0] s;
        logic [4:0] lo;
        logic       v;
        s  = sub ? {1'b0, a} - {1'b0, b} - {8'h00, ci}
                 : {1'b0, a} + {1'b0, b} + {8'h00, ci};
        lo = sub ? {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ci}
                 : {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        v  = sub ? (a[7] ^ b[7]) & (a[7] ^ s[7])
                 : ~(a[7] ^ b[7]) & (a[7] ^ s[7]);
        return {lo[4], s[8], v, s[7:0]};
    endfunction

    function automatic logic [7:0] znvs(input logic [7:0] f,
                                        input logic [7:0] r,
                                        input logic v,
                                        input logic chain);
        // chained zero keeps multi-byte subtract results honest
        f[F_Z] = chain ? f[F_Z] & (r == 8'h00) : (r == 8'h00);
        f[F_N] = r[7];
        f[F_V] = v;
        f[F_S] = r[7] ^ v;
        return f;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    state_t     st_q, st_d;
    logic [2:0] cnt_q, cnt_d;
    logic [7:0] flags_q, flags_d;
    logic       run_q, run_d;
    logic [PC_W-1:0] pc_q, pc_d;
    logic [2:0] cyc_q, cyc_d;
    result_t    out_q, out_d;
    logic       ov_q, ov_d;
    logic       acc;

    // exec combinational values
    logic [7:0]  b_op;
    logic        ci;
    logic        is_sub;
    logic        chain;
    logic [10:0] ar;
    logic [7:0]  fl;
    logic [7:0]  lr;
    logic        sk;
    logic        br;
    logic        cond;
    logic [PC_W-1:0] rel;
    result_t     res;

    assign in_ready  = (st_q == st_idle) && run_q;
    assign acc       = in_valid && in_ready;
    assign out       = out_q;
    assign out_valid = ov_q;
    assign flags     = flags_q;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        b_op   = instr.rr_val;
        ci     = 1'b0;
        is_sub = 1'b1;
        chain  = 1'b0;
        unique case (instr.op)
            op_add: is_sub = 1'b0;
            op_add_carry: begin
                is_sub = 1'b0;
                ci     = flags_q[F_C];
            end
            op_sub_imm, op_cmp_imm: b_op = instr.imm;
            op_sub_carry, op_cmp_carry: begin
                ci    = flags_q[F_C];
                chain = 1'b1;
            end
            sub_imm_with_borrow: begin
                b_op  = instr.imm;
                ci    = flags_q[F_C];
                chain = 1'b1;
            end
            default: b_op = instr.rr_val;
        endcase
        ar = arith(instr.rd_val, b_op, ci, is_sub);
        fl = znvs(flags_q, ar[7:0], ar[8], chain);
        fl[F_C] = ar[9];
        fl[F_H] = ar[10];
        rel = instr.pc + PC_W'($signed(instr.k)) + PC_W'(1);

        res          = '0;
        res.result   = instr.rd_val;
        res.pc_next  = instr.pc + PC_W'(1);
        res.ret_addr = instr.pc + PC_W'(1);
        res.cycles   = CYC_ONE;
        flags_d      = flags_q;
        lr           = instr.rd_val;
        sk           = 1'b0;
        br           = 1'b0;
        cond         = 1'b0;
        unique case (instr.op)
            op_add, op_add_carry, op_sub, op_sub_imm, op_sub_carry,
            sub_imm_with_borrow: begin
                res.wr_en  = 1'b1;
                res.result = ar[7:0];
                flags_d    = fl;
            end
            op_cmp, op_cmp_carry, op_cmp_imm: flags_d = fl;
            op_and, op_or, op_xor, and_with_immediate, op_or_imm,
            set_bits_op, clear_bits_op, test_zero_minus_op: begin
                unique case (instr.op)
                    op_and:             lr = instr.rd_val & instr.rr_val;
                    and_with_immediate: lr = instr.rd_val & instr.imm;
                    op_or:              lr = instr.rd_val | instr.rr_val;
                    op_or_imm, set_bits_op:
                        lr = instr.rd_val | instr.imm;
                    op_xor:             lr = instr.rd_val ^ instr.rr_val;
                    clear_bits_op:
                        lr = instr.rd_val & ~instr.imm;
                    default:
                        lr = instr.rd_val & instr.rd_val;
                endcase
                res.wr_en  = 1'b1;
                res.result = lr;
                flags_d    = znvs(flags_q, lr, 1'b0, 1'b0);
            end
            op_inc, op_dec: begin
                lr = (instr.op == op_inc) ? instr.rd_val + 8'h01
                                          : instr.rd_val - 8'h01;
                res.wr_en  = 1'b1;
                res.result = lr;
                flags_d = znvs(flags_q, lr, (instr.op == op_inc) ?
                               (lr == 8'h80) : (lr == 8'h7f),
                               1'b0);
            end
            relative_jump_op: begin
                res.pc_next = rel;
                res.cycles  = CYC_TWO;
            end
            pointer_jump_op, pointer_call_op: begin
                // upper pc bits forced to zero
                res.pc_next = {{(PC_W-Z_W){1'b0}}, instr.z_ptr};
                res.cycles  = CYC_TWO;
                if (instr.op == pointer_call_op) begin
                    res.push_ret = 1'b1;
                    res.cycles   = CYC_CALL;
                end
            end
            op_return, interrupt_return_op: begin
                res.pc_next = instr.stack_pc;
                res.cycles  = CYC_RET;
                if (instr.op == interrupt_return_op)
                    flags_d[F_I] = 1'b1;
            end
            compare_skip_equal_op: begin
                sk   = 1'b1;
                cond = instr.rd_val == instr.rr_val;
            end
            skip_reg_bit_clear_op, skip_reg_bit_set_op: begin
                sk   = 1'b1;
                cond = instr.rr_val[instr.bit_sel] ==
                       (instr.op == skip_reg_bit_set_op);
            end
            skip_io_bit_clear_op, skip_io_bit_set_op: begin
                sk   = 1'b1;
                cond = instr.io_byte[instr.bit_sel] ==
                       (instr.op == skip_io_bit_set_op);
            end
            branch_flag_set_op, branch_flag_clear_op: begin
                br   = 1'b1;
                cond = flags_q[instr.bit_sel] ==
                       (instr.op == branch_flag_set_op);
            end
            branch_equal_op, branch_not_equal_op: begin
                br   = 1'b1;
                cond = flags_q[F_Z] ==
                       (instr.op == branch_equal_op);
            end
            op_br_carry_set, branch_lower_op: begin
                br   = 1'b1;
                cond = flags_q[F_C];
            end
            op_br_carry_clear, branch_same_higher_op: begin
                br   = 1'b1;
                cond = !flags_q[F_C];
            end
            branch_signed_ge_op, op_br_signed_lt: begin
                br   = 1'b1;
                cond = (flags_q[F_N] ^ flags_q[F_V]) ==
                       (instr.op == op_br_signed_lt);
            end
            branch_minus_op, branch_plus_op: begin
                br   = 1'b1;
                cond = flags_q[F_N] ==
                       (instr.op == branch_minus_op);
            end
            default: res.wr_en = 1'b0;
        endcase
        if (sk && cond) begin
            res.pc_next = instr.pc + (instr.next_two_word ? SKIP_TWO
                                                          : SKIP_ONE);
            res.cycles  = instr.next_two_word ? CYC_SKIP2 : CYC_TWO;
        end
        if (br && cond) begin
            res.pc_next = rel;
            res.cycles  = CYC_TWO;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // ahb-lite slave: zero wait, read data latched in the address phase
    logic        dp_wr_q, dp_wr_d;
    logic [7:0]  dp_ad_q, dp_ad_d;
    logic [31:0] rd_q, rd_d;
    logic        ap;

    assign ap        = hsel && htrans[1] && hready;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rd_q;

    always_comb begin
        dp_wr_d = ap && hwrite;
        dp_ad_d = haddr[7:0];
        rd_d    = 32'h00000000;
        if (ap && !hwrite) begin
            unique case (haddr[7:0])
                A_FLAGS: rd_d = {24'h000000, flags_q};
                A_PC:    rd_d = {10'h000, pc_q};
                A_CTRL:  rd_d = {31'h00000000, run_q};
                A_CYC:   rd_d = {29'h00000000, cyc_q};
                default: rd_d = 32'h00000000;
            endcase
        end
        run_d = run_q;
        if (dp_wr_q && dp_ad_q == A_CTRL)
            run_d = hwdata[0];
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencing: stall decode for the extra cycles of long instructions
    logic [7:0] flags_n;

    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_q;
        out_d = out_q;
        ov_d  = acc;
        pc_d  = pc_q;
        cyc_d = cyc_q;
        flags_n = flags_q;
        // instruction flag updates win over a bus write
        if (dp_wr_q && dp_ad_q == A_FLAGS)
            flags_n = hwdata[7:0];
        if (acc) begin
            flags_n = flags_d;
            out_d   = res;
            pc_d    = res.pc_next;
            cyc_d   = res.cycles;
            if (res.cycles != CYC_ONE) begin
                st_d  = st_busy;
                cnt_d = res.cycles - CYC_ONE;
            end
        end else if (st_q == st_busy) begin
            cnt_d = cnt_q - 3'h1;
            if (cnt_q == 3'h1)
                st_d = st_idle;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q    <= st_idle;
            cnt_q   <= 3'h0;
            flags_q <= FLAGS_RST;
            run_q   <= RUN_RST;
            pc_q    <= PC_RST;
            cyc_q   <= 3'h0;
            out_q   <= '0;
            ov_q    <= 1'b0;
            dp_wr_q <= 1'b0;
            dp_ad_q <= 8'h00;
            rd_q    <= 32'h00000000;
        end else begin
            st_q    <= st_d;
            cnt_q   <= cnt_d;
            flags_q <= flags_n;
            run_q   <= run_d;
            pc_q    <= pc_d;
            cyc_q   <= cyc_d;
            out_q   <= out_d;
            ov_q    <= ov_d;
            dp_wr_q <= dp_wr_d;
            dp_ad_q <= dp_ad_d;
            rd_q    <= rd_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_add_one_cycle: assert property (
        acc && instr.op == op_add |=> ov_q && out_q.wr_en &&
        out_q.cycles == CYC_ONE && in_ready == run_q)
        else $error("add not single cycle");
    a_logic_keep_c: assert property (
        acc && instr.op == op_xor |=> flags_q[F_C] == $past(flags_q[F_C])
        && !flags_q[F_V]) else $error("logic op touched carry");
    a_setbits_or: assert property (
        acc && instr.op == set_bits_op |=> out_q.result ==
        ($past(instr.rd_val) | $past(instr.imm)))
        else $error("set bits result wrong");
    a_clrbits_mask: assert property (
        acc && instr.op == clear_bits_op |=> out_q.result ==
        ($past(instr.rd_val) & ~$past(instr.imm)))
        else $error("clear bits result wrong");
    a_test_keeps: assert property (
        acc && instr.op == test_zero_minus_op |=> out_q.result ==
        $past(instr.rd_val) && flags_q[F_Z] == (out_q.result == 8'h00))
        else $error("test changed value or zero flag");
    a_ptr_jump: assert property (
        acc && instr.op == pointer_jump_op |=> out_q.pc_next ==
        {6'h00, $past(instr.z_ptr)} && !in_ready ##1 in_ready == run_q)
        else $error("pointer jump wrong");
    a_ptr_call: assert property (
        acc && instr.op == pointer_call_op |=> out_q.push_ret
        && !in_ready [*2] ##1 in_ready == run_q)
        else $error("pointer call wrong");
    a_skip_flags: assert property (
        acc && instr.op == compare_skip_equal_op |=> $stable(flags_q))
        else $error("skip changed flags");
    a_branch_ge: assert property (
        acc && instr.op == branch_signed_ge_op &&
        (flags_q[F_N] ^ flags_q[F_V]) |=> out_q.cycles == CYC_ONE)
        else $error("signed ge taken wrongly");
    a_cmp_nowrite: assert property (
        acc && instr.op == op_cmp |=> !out_q.wr_en &&
        flags_q[F_Z] == ($past(instr.rd_val) == $past(instr.rr_val)))
        else $error("compare wrote or bad zero");

    c_branch_taken: cover property (
        acc && br && cond ##1 !in_ready ##1 in_ready);
    c_skip_two: cover property (
        acc && sk && cond && instr.next_two_word);
    c_int_return: cover property (acc && instr.op == interrupt_return_op);

endmodule

/* include/exec_pkg.sv */
// types and constants of the alu and branch execute stage
// assumes a decoder that fills instr_t and a 25 MHz core clock
package exec_pkg;

    localparam int PC_W = 22;
    localparam int Z_W  = 16;

    // status flag bit positions
    localparam int F_C = 0;
    localparam int F_Z = 1;
    localparam int F_N = 2;
    localparam int F_V = 3;
    localparam int F_S = 4;
    localparam int F_H = 5;
    localparam int F_I = 7;

    // register byte offsets on the bus
    localparam logic [7:0] A_FLAGS = 8'h00;
    localparam logic [7:0] A_PC    = 8'h04;
    localparam logic [7:0] A_CTRL  = 8'h08;
    localparam logic [7:0] A_CYC   = 8'h0c;

    // values after reset
    localparam logic [7:0]      FLAGS_RST = 8'h00;
    localparam logic            RUN_RST   = 1'b1;
    localparam logic [PC_W-1:0] PC_RST    = 22'h000000;

    // cycle counts
    localparam logic [2:0] CYC_ONE  = 3'h1;
    localparam logic [2:0] CYC_TWO  = 3'h2;
    localparam logic [2:0] CYC_CALL = 3'h3;
    localparam logic [2:0] CYC_RET  = 3'h4;
    localparam logic [2:0] CYC_SKIP2 = 3'h3;

    // words skipped past a one- or two-word instruction
    localparam logic [PC_W-1:0] SKIP_ONE = 22'h000002;
    localparam logic [PC_W-1:0] SKIP_TWO = 22'h000003;

    typedef enum logic [5:0] {
        op_add, op_add_carry, op_sub, op_sub_imm, op_sub_carry,
        sub_imm_with_borrow, op_and, and_with_immediate, op_or,
        op_or_imm, op_xor, op_inc, op_dec, set_bits_op, clear_bits_op,
        test_zero_minus_op, op_cmp, op_cmp_carry, op_cmp_imm,
        relative_jump_op, pointer_jump_op, pointer_call_op, op_return,
        interrupt_return_op, compare_skip_equal_op,
        skip_reg_bit_clear_op, skip_reg_bit_set_op,
        skip_io_bit_clear_op, skip_io_bit_set_op,
        branch_flag_set_op, branch_flag_clear_op, branch_equal_op,
        branch_not_equal_op, op_br_carry_set, op_br_carry_clear,
        branch_same_higher_op, branch_lower_op, branch_minus_op,
        branch_plus_op, branch_signed_ge_op, op_br_signed_lt
    } op_t;

    typedef struct packed {
        op_t             op;
        logic [7:0]      rd_val;
        logic [7:0]      rr_val;
        logic [7:0]      imm;
        logic [2:0]      bit_sel;
        logic [7:0]      io_byte;
        logic [11:0]     k;
        logic [PC_W-1:0] pc;
        logic [Z_W-1:0]  z_ptr;
        logic [PC_W-1:0] stack_pc;
        logic            next_two_word;
    } instr_t;

    typedef struct packed {
        logic            wr_en;
        logic [7:0]      result;
        logic [PC_W-1:0] pc_next;
        logic            push_ret;
        logic [PC_W-1:0] ret_addr;
        logic [2:0]      cycles;
    } result_t;

endpackage

/* sim/fetch_model.sv */
// decode-side partner: offers one instruction at a time, collects result
// assumes the execute stage answers with a one-cycle out_valid pulse
`timescale 1ns/1ps

module fetch_model
(
    // clock
    input  wire logic              hclk,
    // instruction towards execute
    output logic                   in_valid,
    output exec_pkg::instr_t       instr,
    // answer from execute
    input  wire logic              in_ready,
    input  wire logic              out_valid,
    input  wire exec_pkg::result_t out,
    input  wire logic [7:0]        flags
);
    import exec_pkg::*;

    // idle cycles before each offer, so a slow decode is modelled too
    int gap = 0;

    initial begin
        in_valid = 1'b0;
        instr    = '0;
    end

    ////////////////////////////////////////////////////////////////////
    task automatic send(input instr_t i, output result_t r,
                        output logic [7:0] f, output logic rdy,
                        output logic v);
        int n;
        n = 0;
        repeat (gap) @(posedge hclk);
        @(posedge hclk);
        in_valid <= 1'b1;
        instr    <= i;
        @(negedge hclk);
        while (in_ready !== 1'b1 && n < 50) begin
            n++;
            @(negedge hclk);
        end
        @(posedge hclk);
        in_valid <= 1'b0;
        // a withdrawn offer shows a changed pattern, not the stale word
        instr    <= ~i;
        @(negedge hclk);
        r   = out;
        f   = flags;
        rdy = in_ready;
        v   = out_valid;
    endtask
endmodule

/* sim/tb_alu_and_branch_execute.sv */
// bench for the execute stage: bus tasks plus instruction sequences
// assumes the fetch_model partner and a zero-wait ahb-lite slave
`timescale 1ns/1ps

`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; \
    $display("BAD t=%0t got %h exp %h", $time, g, e); end end

module tb_alu_and_branch_execute;
    import exec_pkg::*;

    localparam logic [PC_W-1:0] PC0 = 22'h3f0100;

    logic            hclk;
    logic            hresetn;
    logic            hsel;
    logic [31:0]     haddr;
    logic [1:0]      htrans;
    logic            hwrite;
    logic [2:0]      hsize;
    logic [31:0]     hwdata;
    logic            hreadyout;
    logic            hresp;
    logic [31:0]     hrdata;
    logic            in_valid;
    logic            in_ready;
    instr_t          instr;
    logic            out_valid;
    result_t         res_w;
    logic [7:0]      flags;
    instr_t          cur;
    result_t         got;
    logic [7:0]      gfl;
    logic            grdy;
    logic            gv;
    int              fails = 0;
    int              checks = 0;

    op_t        bop [16] = '{branch_flag_set_op, branch_flag_clear_op,
        branch_equal_op, branch_not_equal_op, op_br_carry_set,
        op_br_carry_clear, branch_same_higher_op, branch_lower_op,
        branch_signed_ge_op, op_br_signed_lt, branch_signed_ge_op,
        op_br_signed_lt, branch_minus_op, branch_plus_op,
        branch_minus_op, branch_plus_op};
    logic [7:0] bfl [16] = '{8'h02, 8'h02, 8'h02, 8'h02, 8'h01, 8'h01,
        8'h00, 8'h00, 8'h0c, 8'h04, 8'h04, 8'h0c, 8'h04, 8'h04,
        8'h00, 8'h00};
    logic       btk [16] = '{1, 0, 1, 0, 1, 0, 1, 0, 1, 1, 0, 0, 1, 0,
        0, 1};
    op_t        sop [4] = '{skip_reg_bit_clear_op, skip_reg_bit_set_op,
        skip_io_bit_clear_op, skip_io_bit_set_op};

    alu_and_branch_execute dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .in_valid(in_valid),
        .in_ready(in_ready), .instr(instr), .out_valid(out_valid),
        .out(res_w), .flags(flags)
    );

    fetch_model fm (
        .hclk(hclk), .in_valid(in_valid), .instr(instr),
        .in_ready(in_ready), .out_valid(out_valid), .out(res_w),
        .flags(flags)
    );

    ////////////////////////////////////////////////////////////////////
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= w;
        hsize  <= 3'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        // read data taken at the closing edge, before the slave moves on
        rd = hrdata;
    endtask

    task automatic go(input op_t op, input logic [7:0] a,
                      input logic [7:0] b);
        cur.op     = op;
        cur.rd_val = a;
        cur.rr_val = b;
        cur.imm    = b;
        fm.send(cur, got, gfl, grdy, gv);
    endtask

    task automatic chk(input logic wr, input logic [7:0] r,
                       input logic [PC_W-1:0] pn, input logic [2:0] cy,
                       input logic [7:0] fl);
        `CHK(gv, 1'b1)
        `CHK(got.wr_en, wr)
        if (wr) `CHK(got.result, r)
        `CHK(got.pc_next, pn)
        `CHK(got.cycles, cy)
        `CHK(gfl, fl)
        // a multi-cycle instruction holds off the next one
        `CHK(grdy, cy == CYC_ONE)
    endtask

    task automatic report_and_stop();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    initial begin
        #2000000;
        fails++;
        report_and_stop();
    end

    initial begin : main
        logic [31:0]     d;
        logic [PC_W-1:0] ep;
        logic [2:0]      cy;
        hresetn = 1'b0;
        hsel    = 1'b0;
        haddr   = 32'h0;
        htrans  = 2'h0;
        hwrite  = 1'b0;
        hsize   = 3'h2;
        hwdata  = 32'h0;
        cur     = '0;
        cur.pc       = PC0;
        cur.z_ptr    = 16'hbeef;
        cur.stack_pc = 22'h001234;
        cur.k        = 12'hffe;
        cur.io_byte  = 8'h08;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(0, A_FLAGS, 32'h0, d);
        `CHK(d, {24'h0, FLAGS_RST})
        ahb(0, A_CTRL, 32'h0, d);
        `CHK(d, {31'h0, RUN_RST})
        ahb(0, A_PC, 32'h0, d);
        `CHK(d, {10'h0, PC_RST})
        ahb(0, A_CYC, 32'h0, d);
        `CHK(d, 32'h0)
        ahb(0, 8'h10, 32'h0, d);
        `CHK(d, 32'h0)
        `CHK(hresp, 1'b0)
        go(op_add, 8'h0f, 8'h01);
        chk(1, 8'h10, PC0 + 22'h1, CYC_ONE, 8'h20);
        go(op_add, 8'h80, 8'h80);
        chk(1, 8'h00, PC0 + 22'h1, CYC_ONE, 8'h1b);
        go(op_inc, 8'h7f, 8'h00);
        chk(1, 8'h80, PC0 + 22'h1, CYC_ONE, 8'h0d);
        go(sub_imm_with_borrow, 8'h10, 8'h01);
        chk(1, 8'h0e, PC0 + 22'h1, CYC_ONE, 8'h20);
        go(set_bits_op, 8'h40, 8'h81);
        chk(1, 8'hc1, PC0 + 22'h1, CYC_ONE, 8'h34);
        go(op_or_imm, 8'h40, 8'h81);
        chk(1, 8'hc1, PC0 + 22'h1, CYC_ONE, 8'h34);
        go(clear_bits_op, 8'hff, 8'hff);
        chk(1, 8'h00, PC0 + 22'h1, CYC_ONE, 8'h22);
        go(test_zero_minus_op, 8'h90, 8'h00);
        chk(1, 8'h90, PC0 + 22'h1, CYC_ONE, 8'h34);
        go(op_cmp, 8'h05, 8'h05);
        chk(0, 8'h00, PC0 + 22'h1, CYC_ONE, 8'h02);
        go(pointer_jump_op, 8'h00, 8'h00);
        chk(0, 8'h00, 22'h00beef, CYC_TWO, 8'h02);
        go(pointer_call_op, 8'h00, 8'h00);
        chk(0, 8'h00, 22'h00beef, CYC_CALL, 8'h02);
        `CHK({got.push_ret, got.ret_addr}, {1'b1, PC0 + 22'h1})
        for (int i = 0; i < 3; i++) begin
            cur.next_two_word = (i == 2);
            go(compare_skip_equal_op, 8'h33, (i == 0) ? 8'h34 : 8'h33);
            chk(0, 8'h00, PC0 + 22'(i + 1), 3'(i + 1), 8'h02);
        end
        cur.next_two_word = 1'b0;
        for (int j = 0; j < 2; j++) begin
            cur.bit_sel = (j == 0) ? 3'h3 : 3'h2;
            for (int i = 0; i < 4; i++) begin
                go(sop[i], 8'h00, 8'h08);
                ep = (((i % 2) == 1) ^ (j == 1)) ? 22'h2 : 22'h1;
                chk(0, 8'h00, PC0 + ep, ep[2:0], 8'h02);
            end
        end
        cur.bit_sel = 3'h1;
        for (int i = 0; i < 16; i++) begin
            ahb(1, A_FLAGS, {24'h0, bfl[i]}, d);
            go(bop[i], 8'h00, 8'h00);
            ep = btk[i] ? PC0 - 22'h1 : PC0 + 22'h1;
            cy = btk[i] ? CYC_TWO : CYC_ONE;
            chk(0, 8'h00, ep, cy, bfl[i]);
        end
        go(relative_jump_op, 8'h00, 8'h00);
        chk(0, 8'h00, PC0 - 22'h1, CYC_TWO, 8'h00);
        go(op_return, 8'h00, 8'h00);
        chk(0, 8'h00, 22'h001234, CYC_RET, 8'h00);
        go(interrupt_return_op, 8'h00, 8'h00);
        chk(0, 8'h00, 22'h001234, CYC_RET, 8'h80);
        fm.gap = 3;
        go(op_xor, 8'hf0, 8'hff);
        chk(1, 8'h0f, PC0 + 22'h1, CYC_ONE, 8'h80);
        go(op_sub, 8'h00, 8'h01);
        chk(1, 8'hff, PC0 + 22'h1, CYC_ONE, 8'hb5);
        go(op_and, 8'hff, 8'h0f);
        chk(1, 8'h0f, PC0 + 22'h1, CYC_ONE, 8'ha1);
        go(and_with_immediate, 8'h0f, 8'hf0);
        chk(1, 8'h00, PC0 + 22'h1, CYC_ONE, 8'ha3);
        go(op_or, 8'h00, 8'h80);
        chk(1, 8'h80, PC0 + 22'h1, CYC_ONE, 8'hb5);
        go(op_dec, 8'h80, 8'h00);
        chk(1, 8'h7f, PC0 + 22'h1, CYC_ONE, 8'hb9);
        go(op_add_carry, 8'h01, 8'h01);
        chk(1, 8'h03, PC0 + 22'h1, CYC_ONE, 8'h80);
        go(op_sub_imm, 8'h10, 8'h20);
        chk(1, 8'hf0, PC0 + 22'h1, CYC_ONE, 8'h95);
        go(op_cmp_carry, 8'h05, 8'h04);
        chk(0, 8'h00, PC0 + 22'h1, CYC_ONE, 8'h80);
        go(op_cmp_imm, 8'h05, 8'h05);
        chk(0, 8'h00, PC0 + 22'h1, CYC_ONE, 8'h82);
        go(op_sub_carry, 8'h00, 8'h00);
        chk(1, 8'h00, PC0 + 22'h1, CYC_ONE, 8'h82);
        ahb(0, A_PC, 32'h0, d);
        `CHK(d, {10'h0, PC0 + 22'h1})
        ahb(0, A_CYC, 32'h0, d);
        `CHK(d, {29'h0, CYC_ONE})
        ahb(1, A_CTRL, 32'h0, d);
        @(posedge hclk);
        @(negedge hclk);
        `CHK(in_ready, 1'b0)
        ahb(1, A_CTRL, 32'h1, d);
        @(posedge hclk);
        @(negedge hclk);
        `CHK(in_ready, 1'b1)
        report_and_stop();
    end
endmodule
